/* verilog/pmc_power_mode_control.v */
// Overview of operation
// - Bit 1 write requests power-down
// - Bit 7 doubles serial baud rate
// - Bits 3,2 plain flags, kept through idle
// - Both bits set: power-down wins
// - Reset reads 0xxx0000, unused bits zero
// - Reset pin ends idle at once; held 24 oscillator periods it resets
// - Reset clears idle bit asynchronously
// - Few cycles run before internal reset
// - Block RAM, not ports, in that gap
// - Power-down halts oscillator and all functions
// - Power-down keeps state, strobes low
// - Only hardware reset leaves power-down
// - Idle gates only the CPU clock
// - Enabled interrupt clears idle bit
// - Idle holds ports, strobes high
`timescale 1ns/100ps
`include "pmc_map.vh"

module pmc_power_mode_control
#(
    parameter SETTLE_CYC = `PMC_SETTLE_CYC
)
(
    input wire clk_sys, // System clock
    input wire rst, // Async reset, active high
    input wire ext_reset, // External reset pin level
    input wire psel, // APB select
    input wire penable, // APB enable
    input wire pwrite, // APB direction
    input wire [11:0] paddr, // APB address
    input wire [31:0] pwdata, // APB write data
    input wire [3:0] pstrb, // APB byte strobes
    output wire pready, // APB ready
    output reg [31:0] prdata, // APB read data
    output wire pslverr, // APB error
    input wire cpu_wr, // CPU writes power control
    input wire [7:0] cpu_wdata, // CPU write data
    input wire irq_pending, // Enabled interrupt request
    input wire [7:0] port_latch, // Port latch values
    input wire cpu_ale, // CPU address latch strobe
    input wire cpu_fetch, // CPU program fetch strobe
    output reg cpu_clk_en, // CPU clock gate
    output reg periph_clk_en, // Timer/serial/irq clock gate
    output reg osc_run, // Oscillator enable
    output reg baud_double, // Serial baud doubling
    output reg [7:0] port_out, // Port pins
    output reg ale_out, // Address latch strobe pin
    output reg program_fetch_strobe, // Program fetch strobe pin
    output reg ram_access_en, // Internal RAM access allowed
    output reg port_write_en, // Port writes allowed
    output reg internal_reset // Internal reset sequence
);

////////////////////////////////////////////////////////////////////////////////

localparam ST_RUN = 2'd0;
localparam ST_IDLE = 2'd1;
localparam ST_PDOWN = 2'd2;
localparam ST_POST = 2'd3;

localparam [5:0] POST_CYC = `PMC_POST_RESET_CYC;
localparam [4:0] RESET_OSC = `PMC_RESET_OSC;

////////////////////////////////////////////////////////////////////////////////
// Decode helpers

function [7:0] pmc_merge;
    input [7:0] new_val;
    begin
        // Unimplemented bits never stored
        pmc_merge = new_val & `PMC_IMPL_MASK;
    end
endfunction

function pmc_osc_on;
    input [1:0] st;
    begin
        pmc_osc_on = st != ST_PDOWN;
    end
endfunction

function pmc_core_on;
    input [1:0] st;
    begin
        pmc_core_on = (st == ST_RUN) || (st == ST_POST);
    end
endfunction

wire [7:0] power_control_reg_q;
reg [7:0] power_control_reg_d;
reg [7:1] ctrl_upper_q;
reg idle_q;
reg [1:0] state_q;
reg [1:0] state_d;
reg [4:0] rst_cnt_q;
reg [5:0] post_cnt_q;
reg [31:0] settle_cnt_q;

wire idle_bit;
wire power_down_bit;
wire reset_done;
wire apb_access;
wire apb_write;
wire sel_ctrl;
wire sel_status;
wire sel_event;
wire irq_sw;
wire reset_apply;
wire pd_exit;

assign idle_bit = power_control_reg_q[`PMC_BIT_IDLE];
assign power_down_bit = power_control_reg_q[`PMC_BIT_POWER_DOWN];
assign pready = 1'b1;
assign apb_access = psel & penable;
assign apb_write = apb_access & pwrite;
assign sel_ctrl = paddr == `PMC_OFF_POWER_CONTROL;
assign sel_status = paddr == `PMC_OFF_STATUS;
assign sel_event = paddr == `PMC_OFF_CPU_EVENT;
assign pslverr = apb_access & ~(sel_ctrl | sel_status | sel_event);
assign irq_sw = apb_write & sel_event & pstrb[0] & pwdata[`PMC_EV_IRQ];
assign reset_done = rst_cnt_q >= RESET_OSC - 5'd1;
assign power_control_reg_q = {ctrl_upper_q, idle_q};
assign reset_apply = reset_done & ext_reset & (state_q != ST_PDOWN);
assign pd_exit = (state_q == ST_PDOWN) & (state_d == ST_RUN);

////////////////////////////////////////////////////////////////////////////////
// External reset qualification

always @(posedge clk_sys or posedge rst)
begin
    if (rst)
    begin
        rst_cnt_q <= 5'd0;
    end
    else
    begin
        if (!ext_reset)
            rst_cnt_q <= 5'd0;
        else if (!reset_done)
            rst_cnt_q <= rst_cnt_q + 5'd1;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Power control register

always @*
begin
    power_control_reg_d = power_control_reg_q;
    if (cpu_wr)
        power_control_reg_d = pmc_merge(cpu_wdata);
    else if (apb_write && sel_ctrl && pstrb[0])
        power_control_reg_d = pmc_merge(pwdata[7:0]);
    // Hardware clear beats a same-cycle idle write
    if ((irq_pending || irq_sw) && state_q == ST_IDLE)
        power_control_reg_d[`PMC_BIT_IDLE] = 1'b0;
    if (power_control_reg_d[`PMC_BIT_POWER_DOWN])
        power_control_reg_d[`PMC_BIT_IDLE] = 1'b0;
    // Reset sequence reinitialises the register
    if (pd_exit || reset_apply)
        power_control_reg_d = `PMC_RESET_VALUE;
end

always @(posedge clk_sys or posedge rst or posedge ext_reset)
begin
    // Pin clears idle at once, without a clock
    if (rst || ext_reset)
        idle_q <= 1'b0;
    else
        idle_q <= power_control_reg_d[`PMC_BIT_IDLE];
end

always @(posedge clk_sys or posedge rst)
begin
    if (rst)
        ctrl_upper_q <= `PMC_RESET_UPPER;
    else
        ctrl_upper_q <= power_control_reg_d[7:1];
end

////////////////////////////////////////////////////////////////////////////////
// Mode sequencer

always @*
begin
    state_d = state_q;
    case (state_q)
        ST_RUN:
        begin
            if (power_down_bit)
                state_d = ST_PDOWN;
            else if (idle_bit)
                state_d = ST_IDLE;
        end
        ST_IDLE:
        begin
            // Reset pin starts the pre-reset window
            if (ext_reset)
                state_d = ST_POST;
            else if (!idle_bit)
                state_d = ST_RUN;
        end
        ST_PDOWN:
        begin
            if (ext_reset && settle_cnt_q >= SETTLE_CYC - 1)
                state_d = ST_RUN;
        end
        ST_POST:
        begin
            // Window ends when internal reset takes over
            if (reset_apply || post_cnt_q >= POST_CYC - 6'd1)
                state_d = ST_RUN;
        end
        default:
            state_d = ST_RUN;
    endcase
end

always @(posedge clk_sys or posedge rst)
begin
    if (rst)
    begin
        state_q <= ST_RUN;
        post_cnt_q <= 6'd0;
        settle_cnt_q <= 32'd0;
    end
    else
    begin
        state_q <= state_d;
        if (state_q == ST_POST)
            post_cnt_q <= post_cnt_q + 6'd1;
        else
            post_cnt_q <= 6'd0;
        if (state_q == ST_PDOWN && ext_reset)
            settle_cnt_q <= settle_cnt_q + 32'd1;
        else
            settle_cnt_q <= 32'd0;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Pins and gates

always @(posedge clk_sys or posedge rst)
begin
    if (rst)
    begin
        cpu_clk_en <= 1'b1;
        periph_clk_en <= 1'b1;
        osc_run <= 1'b1;
    end
    else
    begin
        // Core clock stops in idle and power-down
        cpu_clk_en <= pmc_core_on(state_d);
        periph_clk_en <= pmc_osc_on(state_d);
        osc_run <= pmc_osc_on(state_d);
    end
end

////////////////////////////////////////////////////////////////////////////////
// Access windows and baud

always @(posedge clk_sys or posedge rst)
begin
    if (rst)
    begin
        baud_double <= 1'b0;
        internal_reset <= 1'b0;
        ram_access_en <= 1'b1;
        port_write_en <= 1'b1;
    end
    else
    begin
        baud_double <= power_control_reg_q[`PMC_BIT_BAUD_DOUBLE];
        // Internal reset once the pin has stood 24 cycles
        internal_reset <= reset_apply;
        ram_access_en <= state_d != ST_POST;
        port_write_en <= pmc_core_on(state_d);
    end
end

////////////////////////////////////////////////////////////////////////////////
// Port pins and strobes

always @(posedge clk_sys or posedge rst)
begin
    if (rst)
    begin
        port_out <= `PMC_PORT_RESET;
        ale_out <= 1'b1;
        program_fetch_strobe <= 1'b1;
    end
    else
    begin
        case (state_d)
            ST_IDLE:
            begin
                ale_out <= 1'b1;
                program_fetch_strobe <= 1'b1;
            end
            ST_PDOWN:
            begin
                port_out <= port_latch;
                ale_out <= 1'b0;
                program_fetch_strobe <= 1'b0;
            end
            default:
            begin
                port_out <= port_latch;
                ale_out <= cpu_ale;
                program_fetch_strobe <= cpu_fetch;
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// Register read

always @(posedge clk_sys or posedge rst)
begin
    if (rst)
        prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
    begin
        prdata <= 32'h0000_0000;
        if (sel_ctrl)
            prdata[7:0] <= power_control_reg_q;
        else if (sel_status)
        begin
            prdata[`PMC_ST_IDLE] <= state_q == ST_IDLE;
            prdata[`PMC_ST_PDOWN] <= state_q == ST_PDOWN;
            prdata[`PMC_ST_POST_RESET] <= state_q == ST_POST;
        end
    end
end

endmodule // pmc_power_mode_control

/* verilog/pmc_map.vh */
`ifndef PMC_MAP_VH
`define PMC_MAP_VH
// Byte offsets on the register bus
`define PMC_OFF_POWER_CONTROL 12'h000
`define PMC_OFF_STATUS 12'h004
`define PMC_OFF_CPU_EVENT 12'h008
// Power control register fields
`define PMC_BIT_IDLE 0
`define PMC_BIT_POWER_DOWN 1
`define PMC_BIT_FLAG_0 2
`define PMC_BIT_FLAG_1 3
`define PMC_BIT_BAUD_DOUBLE 7
`define PMC_IMPL_MASK 8'h8F
`define PMC_RESET_VALUE 8'h00
`define PMC_RESET_UPPER 7'h00
`define PMC_PORT_RESET 8'hFF
// Status fields
`define PMC_ST_IDLE 0
`define PMC_ST_PDOWN 1
`define PMC_ST_POST_RESET 2
// Cpu event register fields
`define PMC_EV_IRQ 0
// Timing
`define PMC_OSC_PER_MCYC 12
`define PMC_RESET_MCYC 2
`define PMC_RESET_OSC (`PMC_RESET_MCYC * `PMC_OSC_PER_MCYC)
`define PMC_POST_RESET_MCYC 3
`define PMC_POST_RESET_CYC (`PMC_POST_RESET_MCYC * `PMC_OSC_PER_MCYC)
`define PMC_SETTLE_MS 10
`define PMC_CLK_MHZ 250
`define PMC_SETTLE_CYC (`PMC_SETTLE_MS * 1000 * `PMC_CLK_MHZ)
`endif

/* verif/pmc_cpu_model.sv */
`timescale 1ns/100ps
module pmc_cpu_model
(
    input wire clk_sys, // Clock
    input wire rst, // Reset
    input wire cpu_clk_en, // Core clock gate
    output reg [7:0] port_latch, // Port latches
    output reg cpu_ale, // Address strobe
    output reg cpu_fetch, // Fetch strobe
    output wire cpu_wr, // Control write
    output wire [7:0] cpu_wdata // Control data
);
    // Core steps only on its gated clock
    always @(posedge clk_sys or posedge rst)
        if (rst)
        begin
            port_latch <= 8'hFF;
            cpu_ale <= 1'b1;
            cpu_fetch <= 1'b1;
        end
        else if (cpu_clk_en)
        begin
            port_latch <= port_latch + 8'h01;
            cpu_ale <= ~cpu_ale;
            cpu_fetch <= cpu_ale;
        end
    // Register left to the bus here
    assign cpu_wr = 1'b0;
    assign cpu_wdata = 8'h00;
endmodule // pmc_cpu_model

/* verif/pmc_power_mode_control_chk.sv */
`timescale 1ns/100ps
module pmc_power_mode_control_chk
(
    input wire clk_sys, // Clock
    input wire rst, // Reset
    input wire ext_reset, // Reset pin
    input wire psel, // Select
    input wire penable, // Enable
    input wire pwrite, // Write
    input wire [11:0] paddr, // Address
    input wire [31:0] pwdata, // Data
    input wire [3:0] pstrb, // Strobes
    input wire cpu_wr, // Core write
    input wire irq_pending, // Interrupt
    input wire cpu_clk_en, // Core clock
    input wire periph_clk_en, // Peripheral clock
    input wire osc_run, // Oscillator
    input wire baud_double, // Baud doubling
    input wire [7:0] port_out, // Ports
    input wire ale_out, // Address strobe
    input wire program_fetch_strobe, // Fetch strobe
    input wire ram_access_en, // Ram allowed
    input wire port_write_en, // Port writes allowed
    input wire internal_reset // Internal reset
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    reg [5:0] hi_q;
    // Reset pin high time while running
    always @(posedge clk_sys or posedge rst)
        if (rst)
            hi_q <= 6'h00;
        else
            hi_q <= (ext_reset && osc_run) ? hi_q + {5'h00, hi_q != 6'h3F} : 6'h00;
    sequence s_wr;
        psel && penable && pwrite && paddr == 12'h000 && pstrb[0] && !cpu_wr;
    endsequence
    sequence s_idle;
        osc_run && !cpu_clk_en;
    endsequence
    pd_entry_a: assert property (s_wr ##0 pwdata[1] |-> ##[1:3] !osc_run)
        else $error("power down not entered");
    pd_strobe_a: assert property (!osc_run [*2] |-> !ale_out && !program_fetch_strobe)
        else $error("strobes not low in power down");
    pd_hold_a: assert property (!osc_run && !ext_reset |=> !osc_run)
        else $error("power down left without reset");
    idle_periph_a: assert property (s_idle |-> periph_clk_en)
        else $error("peripheral clock stopped in idle");
    idle_strobe_a: assert property (s_idle [*2] |-> ale_out && program_fetch_strobe)
        else $error("strobes not high in idle");
    idle_port_a: assert property (s_idle [*2] |-> $stable(port_out))
        else $error("ports moved in idle");
    irq_wake_a: assert property (s_idle ##0 irq_pending && !ext_reset |-> ##[1:3] cpu_clk_en)
        else $error("interrupt did not end idle");
    rst_wake_a: assert property ($rose(ext_reset) && osc_run |-> ##[1:2] cpu_clk_en)
        else $error("reset pin did not end idle");
    gap_port_a: assert property (!ram_access_en |-> port_write_en)
        else $error("port writes blocked");
    int_rst_a: assert property ($rose(internal_reset) |-> hi_q > 6'h15 && hi_q < 6'h1B)
        else $error("internal reset at wrong time");
    baud_a: assert property (s_wr |-> ##2 baud_double == $past(pwdata[7], 2))
        else $error("baud doubling wrong");
endmodule // pmc_power_mode_control_chk
bind pmc_power_mode_control pmc_power_mode_control_chk u_chk (.*);

/* verif/pmc_power_mode_control_tb_top.sv */
`timescale 1ns/100ps
module power_mode_control_tb_top;
    reg clk_sys, rst, ext_reset, psel, penable, pwrite, irq_pending, err;
    reg [11:0] paddr;
    reg [31:0] pwdata, rd, seed, v;
    reg [3:0] pstrb;
    wire pready, pslverr, cpu_clk_en, periph_clk_en, osc_run, baud_double, ale_out;
    wire program_fetch_strobe, ram_access_en, port_write_en, internal_reset;
    wire cpu_ale, cpu_fetch, cpu_wr;
    wire [31:0] prdata;
    wire [7:0] port_out, port_latch, cpu_wdata;
    integer num_errors, checked, cycles, i, n;
    pmc_power_mode_control #(.SETTLE_CYC(20)) u_dut (.*);
    pmc_cpu_model u_cpu (.*);
    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    task chk(input reg [31:0] s, input reg [31:0] e);
        begin
            checked = checked + 1;
            if (s !== e)
            begin
                num_errors = num_errors + 1;
                $display("wrong value at %0t: seen %h expected %h", $time, s, e);
            end
        end
    endtask
    task finish_test;
        begin
            $display("checked %0d num_errors %0d", checked, num_errors);
            if (num_errors == 0 && checked > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    task apb(input reg w, input reg [11:0] a, input reg [31:0] d);
        begin
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clk_sys);
            penable <= 1'b1;
            @(posedge clk_sys);
            while (pready !== 1'b1)
                @(posedge clk_sys);
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge clk_sys);
        end
    endtask
    function [31:0] pc_exp(input reg [31:0] d);
        pc_exp = d & 32'h0000_008F;
    endfunction
    always @(posedge clk_sys)
    begin
        cycles = cycles + 1;
        if (cycles == 3000)
        begin
            num_errors = num_errors + 1;
            finish_test;
        end
    end
    initial
    begin
        {rst, ext_reset, psel, penable, pwrite, irq_pending} = 6'h20;
        {paddr, pwdata, pstrb} = 48'h0000_0000_000F;
        seed = 32'hdf22;
        {num_errors, checked, cycles} = 96'h0;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h0);
        for (i = 0; i < 6; i = i + 1)
        begin
            v = i ? $random(seed) & 32'h0000_008C : 32'h0000_008C;
            apb(1'b1, 12'h000, v);
            apb(1'b0, 12'h000, 32'h0);
            chk(rd, pc_exp(v));
            chk(baud_double, v[7]);
        end
        apb(1'b0, 12'h00C, 32'h0);
        chk(err, 1'b1);
        apb(1'b1, 12'h000, 32'h0000_000D);
        repeat (3) @(posedge clk_sys);
        chk({cpu_clk_en, periph_clk_en, ale_out}, 32'h3);
        irq_pending <= 1'b1;
        for (n = 0; n < 20 && cpu_clk_en !== 1'b1; n = n + 1)
            @(posedge clk_sys);
        irq_pending <= 1'b0;
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h0000_000C);
        apb(1'b1, 12'h000, 32'h0000_0001);
        repeat (3) @(posedge clk_sys);
        ext_reset <= 1'b1;
        repeat (4) @(posedge clk_sys);
        chk({cpu_clk_en, ram_access_en, port_write_en}, 32'h5);
        repeat (24) @(posedge clk_sys);
        chk(internal_reset, 1'b1);
        ext_reset <= 1'b0;
        repeat (60) @(posedge clk_sys);
        apb(1'b1, 12'h000, 32'h0000_0003);
        repeat (3) @(posedge clk_sys);
        chk({osc_run, ale_out, program_fetch_strobe}, 32'h0);
        chk(port_out, port_latch);
        irq_pending <= 1'b1;
        repeat (5) @(posedge clk_sys);
        chk(osc_run, 1'b0);
        irq_pending <= 1'b0;
        ext_reset <= 1'b1;
        for (n = 0; n < 40 && osc_run !== 1'b1; n = n + 1)
            @(posedge clk_sys);
        chk(osc_run, 1'b1);
        ext_reset <= 1'b0;
        repeat (60) @(posedge clk_sys);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h0);
        finish_test;
    end
endmodule // power_mode_control_tb_top
